// *** inc/cmlot_params.svh ***
// constants for the move, logic and stack execution block
`ifndef CMLOT_PARAMS_SVH
`define CMLOT_PARAMS_SVH

// reset values
`define CMLOT_RST_PC 16'h0000
`define CMLOT_RST_SP 8'h07
`define CMLOT_RST_ACC 8'h00
`define CMLOT_RST_DATA_POINTER 16'h0000

// byte lengths and cycle counts
`define CMLOT_N1 2'h1
`define CMLOT_N2 2'h2
`define CMLOT_N3 2'h3

// single opcodes
`define CMLOT_OP_NOP 8'h00
`define CMLOT_OP_XOR_AD 8'h10
`define CMLOT_OP_XOR_AK 8'h11
`define CMLOT_OP_XOR_DA 8'h12
`define CMLOT_OP_XOR_DK 8'h13
`define CMLOT_OP_MOV_AD 8'h20
`define CMLOT_OP_MOV_DD 8'h24
`define CMLOT_OP_MOV_DK 8'h25
`define CMLOT_OP_LD_DATA_POINTER 8'h40
`define CMLOT_OP_CODE_DATA_POINTER 8'h41
`define CMLOT_OP_CODE_PC 8'h42
`define CMLOT_OP_XRD_DATA_POINTER 8'h44
`define CMLOT_OP_XWR_DATA_POINTER 8'h45
`define CMLOT_OP_PUSH 8'h50
`define CMLOT_OP_POP 8'h51
// groups by opcode[7:3], low three bits pick the working register; rotate matches opcode[7:2], low two bits pick the form
`define CMLOT_GRP_XOR_R 5'h01
`define CMLOT_GRP_ROT 5'h03
`define CMLOT_GRP_MOV_RD 5'h05
`define CMLOT_GRP_MOV_RK 5'h06
// pairs by opcode[7:1], low bit picks the indirect pointer
`define CMLOT_PAIR_XOR_I 7'h0A
`define CMLOT_PAIR_MOV_AI 7'h11
`define CMLOT_PAIR_MOV_DI 7'h13
`define CMLOT_PAIR_MOV_IA 7'h1C
`define CMLOT_PAIR_XRD_RI 7'h23
`define CMLOT_PAIR_XWR_RI 7'h24

`endif

// *** inc/cmlot_pkg.sv ***
// types shared by the execution core and its decoder
package cmlot_pkg;

  // instruction classes
  typedef enum logic [4:0] {
    CMLOT_NOP, CMLOT_XOR_R, CMLOT_XOR_D, CMLOT_XOR_I, CMLOT_XOR_K,
    CMLOT_XOR_DA, CMLOT_XOR_DK, CMLOT_ROT, CMLOT_MOV_AD, CMLOT_MOV_AI,
    CMLOT_MOV_DD, CMLOT_MOV_DK, CMLOT_MOV_DI, CMLOT_MOV_RD, CMLOT_MOV_RK,
    CMLOT_MOV_IA, CMLOT_LD_DATA_POINTER, CMLOT_CODE_DATA_POINTER, CMLOT_CODE_PC,
    CMLOT_XRD_DATA_POINTER, CMLOT_XWR_DATA_POINTER, CMLOT_XRD_RI, CMLOT_XWR_RI,
    CMLOT_PUSH, CMLOT_POP
  } cmlot_class_t;

  // cycle within an instruction, gray along c0 -> c1 -> c2
  typedef enum logic [1:0] {
    CMLOT_C0 = 2'h0,
    CMLOT_C1 = 2'h1,
    CMLOT_C2 = 2'h3
  } cmlot_cyc_t;

endpackage

// *** logic/cmlot_decode.sv ***
// opcode decoder: class, byte length and cycle count
`timescale 1ns/1ns
`default_nettype none
`include "cmlot_params.svh"

module cmlot_decode (
  input wire logic [7:0] OPCODE,
  output cmlot_pkg::cmlot_class_t CLS,
  output logic [1:0] LEN,
  output logic [1:0] CYCLES
);
  import cmlot_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // class from opcode; unknown codes run as a one-cycle no-op
  always_comb begin
    CLS = CMLOT_NOP;
    case (OPCODE)
      `CMLOT_OP_XOR_AD: CLS = CMLOT_XOR_D;
      `CMLOT_OP_XOR_AK: CLS = CMLOT_XOR_K;
      `CMLOT_OP_XOR_DA: CLS = CMLOT_XOR_DA;
      `CMLOT_OP_XOR_DK: CLS = CMLOT_XOR_DK;
      `CMLOT_OP_MOV_AD: CLS = CMLOT_MOV_AD;
      `CMLOT_OP_MOV_DD: CLS = CMLOT_MOV_DD;
      `CMLOT_OP_MOV_DK: CLS = CMLOT_MOV_DK;
      `CMLOT_OP_LD_DATA_POINTER: CLS = CMLOT_LD_DATA_POINTER;
      `CMLOT_OP_CODE_DATA_POINTER: CLS = CMLOT_CODE_DATA_POINTER;
      `CMLOT_OP_CODE_PC: CLS = CMLOT_CODE_PC;
      `CMLOT_OP_XRD_DATA_POINTER: CLS = CMLOT_XRD_DATA_POINTER;
      `CMLOT_OP_XWR_DATA_POINTER: CLS = CMLOT_XWR_DATA_POINTER;
      `CMLOT_OP_PUSH: CLS = CMLOT_PUSH;
      `CMLOT_OP_POP: CLS = CMLOT_POP;
      default: begin
        // register groups, then pointer pairs
        if (OPCODE[7:3] == `CMLOT_GRP_XOR_R) CLS = CMLOT_XOR_R;
        else if (OPCODE[7:3] == `CMLOT_GRP_MOV_RD) CLS = CMLOT_MOV_RD;
        else if (OPCODE[7:3] == `CMLOT_GRP_MOV_RK) CLS = CMLOT_MOV_RK;
        else if (OPCODE[7:2] == {`CMLOT_GRP_ROT, 1'b0}) CLS = CMLOT_ROT;
        else if (OPCODE[7:1] == `CMLOT_PAIR_XOR_I) CLS = CMLOT_XOR_I;
        else if (OPCODE[7:1] == `CMLOT_PAIR_MOV_AI) CLS = CMLOT_MOV_AI;
        else if (OPCODE[7:1] == `CMLOT_PAIR_MOV_DI) CLS = CMLOT_MOV_DI;
        else if (OPCODE[7:1] == `CMLOT_PAIR_MOV_IA) CLS = CMLOT_MOV_IA;
        else if (OPCODE[7:1] == `CMLOT_PAIR_XRD_RI) CLS = CMLOT_XRD_RI;
        else if (OPCODE[7:1] == `CMLOT_PAIR_XWR_RI) CLS = CMLOT_XWR_RI;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bytes and cycles per class
  always_comb begin
    LEN = `CMLOT_N1;
    CYCLES = `CMLOT_N1;
    case (CLS)
      CMLOT_XOR_R, CMLOT_ROT, CMLOT_NOP: begin
        LEN = `CMLOT_N1;
        CYCLES = `CMLOT_N1;
      end
      CMLOT_XOR_I, CMLOT_MOV_AI, CMLOT_MOV_IA: begin
        LEN = `CMLOT_N1;
        CYCLES = `CMLOT_N2;
      end
      CMLOT_XOR_D, CMLOT_XOR_K, CMLOT_XOR_DA, CMLOT_MOV_AD, CMLOT_MOV_RD,
      CMLOT_MOV_RK, CMLOT_MOV_DI, CMLOT_PUSH, CMLOT_POP: begin
        LEN = `CMLOT_N2;
        CYCLES = `CMLOT_N2;
      end
      CMLOT_XOR_DK, CMLOT_MOV_DD, CMLOT_MOV_DK, CMLOT_LD_DATA_POINTER: begin
        LEN = `CMLOT_N3;
        CYCLES = `CMLOT_N3;
      end
      CMLOT_CODE_DATA_POINTER, CMLOT_CODE_PC, CMLOT_XRD_DATA_POINTER, CMLOT_XWR_DATA_POINTER,
      CMLOT_XRD_RI, CMLOT_XWR_RI: begin
        LEN = `CMLOT_N1;
        CYCLES = `CMLOT_N3;
      end
      default: begin
        LEN = `CMLOT_N1;
        CYCLES = `CMLOT_N1;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** logic/cmlot_core.sv ***
// execution core for xor, rotate, move, code read, external data and stack
`timescale 1ns/1ns
`default_nettype none
`include "cmlot_params.svh"

module cmlot_core (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  output logic [15:0] CODE_ADDR,
  input wire logic [7:0] CODE_DATA,
  output logic [15:0] XDATA_ADDR,
  output logic [7:0] XDATA_WDATA,
  input wire logic [7:0] XDATA_RDATA,
  output logic XDATA_RD,
  output logic XDATA_WR,
  output logic OPCODE_FETCH,
  output logic [7:0] ACC_OUT,
  output logic CARRY_OUT,
  output logic [15:0] DATA_POINTER_OUT,
  output logic [7:0] SP_OUT,
  output logic [15:0] PC_OUT
);
  import cmlot_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // position of a cycle state as a count
  function automatic logic [1:0] cyc_index(input cmlot_cyc_t c);
    case (c)
      CMLOT_C0: cyc_index = 2'h0;
      CMLOT_C1: cyc_index = 2'h1;
      CMLOT_C2: cyc_index = 2'h2;
      default: cyc_index = 2'h0;
    endcase
  endfunction

  // address of working register n in the low bank
  function automatic logic [7:0] reg_addr(input logic [2:0] n);
    reg_addr = {5'h00, n};
  endfunction

  // accumulator rotate, sel 0 left, 1 left via carry, 2 right, 3 right via carry
  function automatic logic [8:0] rotate(input logic [1:0] sel, input logic [7:0] a, input logic c);
    case (sel)
      2'h0: rotate = {c, a[6:0], a[7]};
      2'h1: rotate = {a[7], a[6:0], c};
      2'h2: rotate = {c, a[0], a[7:1]};
      2'h3: rotate = {a[0], c, a[7:1]};
      default: rotate = {c, a};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  cmlot_cyc_t cyc_q; // cycle within instruction
  cmlot_cyc_t cyc_d;
  logic [15:0] pc_q; // address of next code byte
  logic [7:0] op_q; // opcode held after cycle 0
  logic [7:0] b1_q; // first operand byte
  logic [7:0] acc_q; // accumulator
  logic [7:0] acc_d;
  logic carry_q; // carry flag
  logic carry_d;
  logic [15:0] data_pointer_q; // data pointer
  logic [15:0] data_pointer_d;
  logic [7:0] sp_q; // stack pointer
  logic [7:0] sp_d;
  logic [7:0] tmp_q; // byte fetched from code space
  logic [7:0] ram [0:255]; // internal data memory, working registers at 0..7
  // external strobe registers, live during cycle 1
  logic [15:0] xaddr_q;
  logic [7:0] xwdata_q;
  logic xrd_q;
  logic xwr_q;

  // decode of the current opcode
  logic [7:0] cur_op; // opcode seen this cycle
  logic [7:0] cur_b1; // first operand this cycle
  cmlot_class_t cls; // instruction class
  logic [1:0] len; // bytes in the instruction
  logic [1:0] cycles; // cycles the instruction takes
  logic [1:0] idx; // current cycle number
  logic last; // final cycle of the instruction
  logic fetch_byte; // this cycle consumes a code byte
  logic [7:0] ptr_val; // content of the chosen indirect pointer
  logic [15:0] code_rd_addr; // table lookup address
  // internal memory write port
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;

  ////////////////////////////////////////////////////////////////////////
  // decode

  // in cycle 0 the opcode comes straight from code memory
  assign idx = cyc_index(cyc_q);
  assign cur_op = (cyc_q == CMLOT_C0) ? CODE_DATA : op_q;
  assign cur_b1 = (cyc_q == CMLOT_C1) ? CODE_DATA : b1_q;

  cmlot_decode u_decode (
    .OPCODE(cur_op),
    .CLS(cls),
    .LEN(len),
    .CYCLES(cycles)
  );

  // the instruction ends on its last counted cycle
  assign last = (idx == (cycles - 2'h1));
  // only the instruction's own bytes advance the pc
  assign fetch_byte = (idx < len);
  // low opcode bit picks pointer 0 or 1
  assign ptr_val = ram[reg_addr({2'h0, cur_op[0]})];

  // pc already points past the opcode when the lookup runs
  assign code_rd_addr = (op_q == `CMLOT_OP_CODE_PC) ? (pc_q + {8'h00, acc_q})
                                                    : (data_pointer_q + {8'h00, acc_q});

  // code address: table lookup in cycle 1, otherwise the pc
  // held opcode only, so the address never loops back through the code byte
  always_comb begin
    CODE_ADDR = pc_q;
    if ((cyc_q == CMLOT_C1) && ((op_q == `CMLOT_OP_CODE_PC) || (op_q == `CMLOT_OP_CODE_DATA_POINTER))) begin
      CODE_ADDR = code_rd_addr;
    end
  end

  assign OPCODE_FETCH = (cyc_q == CMLOT_C0);

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencing
  always_comb begin
    case (cyc_q)
      CMLOT_C0: cyc_d = last ? CMLOT_C0 : CMLOT_C1;
      CMLOT_C1: cyc_d = last ? CMLOT_C0 : CMLOT_C2;
      CMLOT_C2: cyc_d = CMLOT_C0;
      default: cyc_d = CMLOT_C0;
    endcase
  end

  // cycle state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cyc_q <= CMLOT_C0;
    end else if (CE) begin
      cyc_q <= cyc_d;
    end
  end

  // program counter and operand latches
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pc_q <= `CMLOT_RST_PC;
      op_q <= 8'h00;
      b1_q <= 8'h00;
    end else if (CE) begin
      if (fetch_byte) begin
        pc_q <= pc_q + 16'h0001;
      end
      if (cyc_q == CMLOT_C0) begin
        op_q <= CODE_DATA;
      end
      if (cyc_q == CMLOT_C1) begin
        b1_q <= CODE_DATA;
      end
    end
  end

  // table byte caught in cycle 1, moved to acc in cycle 2
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tmp_q <= 8'h00;
    end else if (CE && (cyc_q == CMLOT_C1)) begin
      tmp_q <= CODE_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execute: one write port into data memory per cycle
  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    data_pointer_d = data_pointer_q;
    sp_d = sp_q;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    if (last) begin
      case (cls)
        CMLOT_XOR_R: acc_d = acc_q ^ ram[reg_addr(cur_op[2:0])];
        CMLOT_XOR_D: acc_d = acc_q ^ ram[cur_b1];
        CMLOT_XOR_I: acc_d = acc_q ^ ram[ptr_val];
        CMLOT_XOR_K: acc_d = acc_q ^ cur_b1;
        CMLOT_XOR_DA: begin
          // result lands in the addressed byte
          ram_we = 1'b1;
          ram_wa = cur_b1;
          ram_wd = ram[cur_b1] ^ acc_q;
        end
        CMLOT_XOR_DK: begin
          ram_we = 1'b1;
          ram_wa = b1_q;
          ram_wd = ram[b1_q] ^ CODE_DATA;
        end
        CMLOT_ROT: begin
          // through-carry forms shift the flag in and out
          {carry_d, acc_d} = rotate(cur_op[1:0], acc_q, carry_q);
        end
        CMLOT_MOV_AD: acc_d = ram[cur_b1];
        CMLOT_MOV_AI: acc_d = ram[ptr_val];
        CMLOT_MOV_RD: begin
          ram_we = 1'b1;
          ram_wa = reg_addr(cur_op[2:0]);
          ram_wd = ram[cur_b1];
        end
        CMLOT_MOV_RK: begin
          ram_we = 1'b1;
          ram_wa = reg_addr(cur_op[2:0]);
          ram_wd = cur_b1;
        end
        CMLOT_MOV_DD: begin
          // first operand is source, second is destination
          ram_we = 1'b1;
          ram_wa = CODE_DATA;
          ram_wd = ram[b1_q];
        end
        CMLOT_MOV_DK: begin
          ram_we = 1'b1;
          ram_wa = b1_q;
          ram_wd = CODE_DATA;
        end
        CMLOT_MOV_DI: begin
          ram_we = 1'b1;
          ram_wa = cur_b1;
          ram_wd = ram[ptr_val];
        end
        CMLOT_MOV_IA: begin
          ram_we = 1'b1;
          ram_wa = ptr_val;
          ram_wd = acc_q;
        end
        CMLOT_LD_DATA_POINTER: data_pointer_d = {b1_q, CODE_DATA};
        CMLOT_CODE_DATA_POINTER, CMLOT_CODE_PC: acc_d = tmp_q;
        CMLOT_XRD_DATA_POINTER, CMLOT_XRD_RI: acc_d = XDATA_RDATA;
        CMLOT_PUSH: begin
          // bump first, then store at the new top
          sp_d = sp_q + 8'h01;
          ram_we = 1'b1;
          ram_wa = sp_q + 8'h01;
          ram_wd = ram[cur_b1];
        end
        CMLOT_POP: begin
          // read the top, then drop the pointer
          ram_we = 1'b1;
          ram_wa = cur_b1;
          ram_wd = ram[sp_q];
          sp_d = sp_q - 8'h01;
        end
        default: begin
          // no-op and external writes change no core state here
          acc_d = acc_q;
        end
      endcase
    end
  end

  // accumulator and carry
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      acc_q <= `CMLOT_RST_ACC;
      carry_q <= 1'b0;
    end else if (CE) begin
      acc_q <= acc_d;
      carry_q <= carry_d;
    end
  end

  // data pointer and stack pointer
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      data_pointer_q <= `CMLOT_RST_DATA_POINTER;
      sp_q <= `CMLOT_RST_SP;
    end else if (CE) begin
      data_pointer_q <= data_pointer_d;
      sp_q <= sp_d;
    end
  end

  // data memory; not cleared by reset, contents are software's business
  always_ff @(posedge CLK) begin
    if (CE && ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external data port: address and strobe set at end of cycle 0, held for cycle 1
  // the far memory answers reads one cycle later, so data is taken in cycle 2
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      xaddr_q <= 16'h0000;
      xwdata_q <= 8'h00;
      xrd_q <= 1'b0;
      xwr_q <= 1'b0;
    end else if (CE) begin
      xrd_q <= 1'b0;
      xwr_q <= 1'b0;
      if (cyc_q == CMLOT_C0) begin
        case (cls)
          CMLOT_XRD_DATA_POINTER, CMLOT_XWR_DATA_POINTER: begin
            xaddr_q <= data_pointer_q;
            xwdata_q <= acc_q;
            xrd_q <= (cls == CMLOT_XRD_DATA_POINTER);
            xwr_q <= (cls == CMLOT_XWR_DATA_POINTER);
          end
          CMLOT_XRD_RI, CMLOT_XWR_RI: begin
            // upper address byte is zero for the short form
            xaddr_q <= {8'h00, ptr_val};
            xwdata_q <= acc_q;
            xrd_q <= (cls == CMLOT_XRD_RI);
            xwr_q <= (cls == CMLOT_XWR_RI);
          end
          default: begin
            xaddr_q <= xaddr_q;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign XDATA_ADDR = xaddr_q;
  assign XDATA_WDATA = xwdata_q;
  assign XDATA_RD = xrd_q;
  assign XDATA_WR = xwr_q;
  assign ACC_OUT = acc_q;
  assign CARRY_OUT = carry_q;
  assign DATA_POINTER_OUT = data_pointer_q;
  assign SP_OUT = sp_q;
  assign PC_OUT = pc_q;

endmodule
`default_nettype wire

// *** sim/cmlot_chk_sva.sv ***
// timing and strobe assertions for the execution core
`timescale 1ns/1ns
`default_nettype none
module cmlot_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [7:0] CODE_DATA,
  input wire logic [15:0] XDATA_ADDR,
  input wire logic [7:0] XDATA_WDATA,
  input wire logic XDATA_RD,
  input wire logic XDATA_WR,
  input wire logic OPCODE_FETCH,
  input wire logic [7:0] ACC_OUT,
  input wire logic CARRY_OUT,
  input wire logic [15:0] DATA_POINTER_OUT,
  input wire logic [7:0] SP_OUT,
  input wire logic [15:0] PC_OUT
);
  logic f; // opcode taken at this edge
  logic two; // two-cycle opcode
  logic three; // three-cycle opcode
  logic [15:0] blen; // byte length of the opcode
  assign f = OPCODE_FETCH && CE;
  assign two = CODE_DATA inside {8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h20, 8'h22, 8'h23, 8'h26, 8'h27,
    8'h38, 8'h39, 8'h50, 8'h51} || CODE_DATA[7:3] inside {5'h05, 5'h06};
  assign three = CODE_DATA inside {8'h13, 8'h24, 8'h25, [8'h40:8'h42], [8'h44:8'h49]};
  // own length table, so a wrong decoder length shows as a pc slip
  always_comb begin
    blen = 16'h0002;
    if (CODE_DATA inside {8'h13, 8'h24, 8'h25, 8'h40}) begin
      blen = 16'h0003;
    end else if (CODE_DATA inside {8'h14, 8'h15, 8'h22, 8'h23, 8'h38, 8'h39, 8'h41, 8'h42, [8'h44:8'h49]}) begin
      blen = 16'h0001; // indirect, lookup and external forms
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  one_cycle_a:
  assert property (f && !two && !three |=> OPCODE_FETCH && PC_OUT == $past(PC_OUT) + 16'h0001)
    else $error("single-cycle opcode timing wrong");
  rot_left_a:
  assert property (f && CODE_DATA == 8'h18 |=>
    ACC_OUT == {$past(ACC_OUT[6:0]), $past(ACC_OUT[7])} && CARRY_OUT == $past(CARRY_OUT))
    else $error("left rotate result wrong");
  multi_cyc_a:
  assert property (f && (two || three) |=> !OPCODE_FETCH) else $error("multi-cycle opcode ended early");
  two_cyc_a:
  assert property (f && two ##1 CE |=> OPCODE_FETCH && PC_OUT == $past(PC_OUT, 2) + $past(blen, 2))
    else $error("two-cycle opcode timing wrong");
  three_mid_a:
  assert property (f && three ##1 CE |=> !OPCODE_FETCH) else $error("three-cycle opcode ended early");
  three_cyc_a:
  assert property (f && three ##1 CE [*2] |=> OPCODE_FETCH && PC_OUT == $past(PC_OUT, 3) + $past(blen, 3))
    else $error("three-cycle opcode timing wrong");
  xrd_data_pointer_a:
  assert property (f && CODE_DATA == 8'h44 |=> XDATA_RD && !XDATA_WR && XDATA_ADDR == $past(DATA_POINTER_OUT))
    else $error("pointer read strobe wrong");
  xwr_data_pointer_a:
  assert property (f && CODE_DATA == 8'h45 |=> XDATA_WR && !XDATA_RD && XDATA_ADDR == $past(DATA_POINTER_OUT)
    && XDATA_WDATA == $past(ACC_OUT)) else $error("pointer write strobe wrong");
  xri_a:
  assert property (f && CODE_DATA inside {[8'h46:8'h49]} |=> ($past(CODE_DATA[3]) ? XDATA_WR : XDATA_RD)
    && XDATA_ADDR[15:8] == 8'h00) else $error("short pointer access wrong");
  strobe_pulse_a:
  assert property (CE && (XDATA_RD || XDATA_WR) |=> !XDATA_RD && !XDATA_WR) else $error("strobe too long");
  push_sp_a:
  assert property (f && CODE_DATA == 8'h50 ##1 CE |=> SP_OUT == $past(SP_OUT, 2) + 8'h01)
    else $error("push stack pointer wrong");
  pop_sp_a:
  assert property (f && CODE_DATA == 8'h51 ##1 CE |=> SP_OUT == $past(SP_OUT, 2) - 8'h01)
    else $error("pop stack pointer wrong");
endmodule
bind cmlot_core cmlot_chk u_chk (.CLK(CLK), .NRST(NRST), .CE(CE), .CODE_DATA(CODE_DATA),
  .XDATA_ADDR(XDATA_ADDR), .XDATA_WDATA(XDATA_WDATA), .XDATA_RD(XDATA_RD), .XDATA_WR(XDATA_WR),
  .OPCODE_FETCH(OPCODE_FETCH), .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT), .DATA_POINTER_OUT(DATA_POINTER_OUT),
  .SP_OUT(SP_OUT), .PC_OUT(PC_OUT));
`default_nettype wire

// *** sim/cmlot_mem_model.sv ***
// code memory and external data memory beside the core
`timescale 1ns/1ns
`default_nettype none
module cmlot_mem_model (
  input wire logic clk,
  input wire logic ce,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_data,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  output logic [7:0] xdata_rdata,
  input wire logic xdata_rd,
  input wire logic xdata_wr
);
  logic [7:0] rom [256]; // program bytes, aliased every 256
  logic [7:0] xmem [256]; // external data, aliased every 256
  logic [15:0] waddr_q; // full address of the last write
  logic rd_q = 1'b0; // read answer due this cycle
  logic [7:0] last_q = 8'hA5; // last byte on the read lines
  ////////////////////////////////////////
  // async code read: the byte must be there in the address cycle
  assign code_data = rom[code_addr[7:0]];
  // outside the answer cycle the lines toggle, so a late sample cannot pass
  assign xdata_rdata = rd_q ? xmem[xdata_addr[7:0]] : ~last_q;
  // write on the strobe edge, answer one cycle after the read strobe
  always @(posedge clk) begin
    if (ce) begin
      rd_q <= xdata_rd;
      last_q <= xdata_rdata;
      if (xdata_wr) begin
        xmem[xdata_addr[7:0]] <= xdata_wdata;
        waddr_q <= xdata_addr;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the execution core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef logic [7:0] cmlot_bytes_t [$]; // program image
  logic clk, nrst, ce; // driven inputs
  logic [15:0] caddr, xaddr, data_pointer, pc; // core addresses
  logic [7:0] cdata, xwdata, xrdata, acc, sp; // core data
  logic xrd, xwr, fetch, carry; // strobes and flags
  int n_fail; // mismatches
  int checked; // comparisons made
  cmlot_core DUT (.CLK(clk), .NRST(nrst), .CE(ce), .CODE_ADDR(caddr), .CODE_DATA(cdata), .XDATA_ADDR(xaddr),
    .XDATA_WDATA(xwdata), .XDATA_RDATA(xrdata), .XDATA_RD(xrd), .XDATA_WR(xwr), .OPCODE_FETCH(fetch),
    .ACC_OUT(acc), .CARRY_OUT(carry), .DATA_POINTER_OUT(data_pointer), .SP_OUT(sp), .PC_OUT(pc));
  cmlot_mem_model u_mem (.clk(clk), .ce(ce), .code_addr(caddr), .code_data(cdata), .xdata_addr(xaddr),
    .xdata_wdata(xwdata), .xdata_rdata(xrdata), .xdata_rd(xrd), .xdata_wr(xwr));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // one compare for every result, widened to 16 bits
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // image loaded under reset; one extra byte serves the table lookups
  task automatic load(input cmlot_bytes_t p, input int a, input logic [7:0] b);
    @(posedge clk);
    #10;
    nrst = 1'b0;
    for (int i = 0; i < 256; i++) begin
      u_mem.rom[i] = (i < p.size()) ? p[i] : 8'h00;
    end
    u_mem.rom[a] = b;
    @(posedge clk);
    #10;
    nrst = 1'b1;
  endtask
  // step whole cycles, sampling after the edge has settled
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic t_xor;
    load('{8'h25, 8'h40, 8'h5A, 8'h11, 8'h0F, 8'h10, 8'h40, 8'h30, 8'h33, 8'h08, 8'h30, 8'h40, 8'h14,
      8'h12, 8'h40, 8'h13, 8'h40, 8'hFF, 8'h20, 8'h40}, 255, 8'h00);
    run(10);
    chk("pc", 16'h000A, pc);
    chk("acc", 16'h0066, {8'h00, acc});
    run(11);
    chk("pc", 16'h0014, pc);
    chk("acc", 16'h0099, {8'h00, acc});
    $display("test xor done");
  endtask
  task automatic t_rot;
    load('{8'h11, 8'h81, 8'h18, 8'h1B, 8'h1A, 8'h19}, 255, 8'h00);
    run(5);
    chk("acc", 16'h0080, {8'h00, acc});
    chk("carry", 16'h0001, {15'h0000, carry});
    run(1);
    chk("acc", 16'h0001, {8'h00, acc});
    chk("pc", 16'h0006, pc);
    $display("test rotate done");
  endtask
  task automatic t_move;
    load('{8'h25, 8'h41, 8'hC3, 8'h24, 8'h41, 8'h42, 8'h31, 8'h42, 8'h27, 8'h43, 8'h2A, 8'h43, 8'h11,
      8'h3C, 8'h30, 8'h44, 8'h38, 8'h23, 8'h22, 8'h0A}, 255, 8'h00);
    run(20);
    chk("acc", 16'h00C3, {8'h00, acc});
    run(2);
    chk("acc", 16'h003C, {8'h00, acc});
    run(1);
    chk("acc", 16'h00FF, {8'h00, acc});
    chk("pc", 16'h0014, pc);
    $display("test move done");
  endtask
  task automatic t_ext;
    load('{8'h40, 8'h12, 8'h34, 8'h11, 8'h05, 8'h45, 8'h41, 8'h42, 8'h44, 8'h30, 8'h80, 8'h31, 8'h90,
      8'h48, 8'h11, 8'hFF, 8'h49, 8'h46}, 8'h39, 8'h09);
    run(14);
    chk("data_pointer", 16'h1234, data_pointer);
    chk("waddr", 16'h1234, u_mem.waddr_q);
    chk("acc", 16'h0046, {8'h00, acc});
    chk("pc", 16'h0008, pc);
    run(18);
    chk("acc", 16'h0005, {8'h00, acc});
    chk("xmem90", 16'h00FA, {8'h00, u_mem.xmem[8'h90]});
    chk("waddr", 16'h0090, u_mem.waddr_q);
    chk("pc", 16'h0012, pc);
    $display("test external done");
  endtask
  task automatic t_stack;
    load('{8'h25, 8'h50, 8'hAB, 8'h50, 8'h50, 8'h20, 8'h08, 8'h51, 8'h60, 8'h10, 8'h60}, 255, 8'h00);
    run(7);
    chk("sp", 16'h0008, {8'h00, sp});
    chk("acc", 16'h00AB, {8'h00, acc});
    run(4);
    chk("sp", 16'h0007, {8'h00, sp});
    chk("acc", 16'h0000, {8'h00, acc});
    chk("pc", 16'h000B, pc);
    $display("test stack done");
  endtask
  // enable low must freeze the core; unknown opcode runs as a short no-op
  task automatic t_hold;
    load('{8'hFF, 8'h11, 8'h22}, 255, 8'h00);
    ce = 1'b0;
    run(3);
    chk("pc", 16'h0000, pc);
    ce = 1'b1;
    run(3);
    chk("pc", 16'h0003, pc);
    chk("acc", 16'h0022, {8'h00, acc});
    $display("test enable done");
  endtask
  task automatic end_sim;
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // about 125 cycles of tests, so 2000 cycles means a hang
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    #10;
    nrst = 1'b1;
    t_xor;
    t_rot;
    t_move;
    t_ext;
    t_stack;
    t_hold;
    end_sim;
  end
endmodule
`default_nettype wire
